// >>> design/vmei_top.sv
// VMEbus interrupter: source latching, level mapping and acknowledge answer
//
// Notes on behaviour
// - Any combination of request lines 1 to 7 may be driven together.
// - Each source has its own enable bit gating its request line.
// - Each mappable source has a level field; level 0 drives nothing.
// - A firing source sets its status bit and, if enabled, its line.
// - Answer only with daisy-chain input asserted, returning the stored vector.
// - As system controller the daisy-chain input is ignored.
// - Seven fixed soft bits each drive their own level, no mapping.
// - Vector is one 8-bit value common to all levels.
// - Upper seven bits programmed; lsb 0 for soft, 1 otherwise.
// - Soft source wins over others sharing the acknowledged level.
// - After a soft vector, raise an ack-done event, routable to local line.
// - Soft request and its status clear together when acknowledge completes.
// - Other sources stay asserted until status is written with one.
// - Local inputs are level sensitive and raise requests at once.
// - Clearing status while a local input is high keeps the request.
`timescale 1ns/1ps
`default_nettype none
`include "vmei_consts.svh"
module vmei_top (
  // Clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // AXI4-Lite register bus
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [7:0]          awaddr,
  input  wire logic                wvalid,
  output logic                     wready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  output logic                     bvalid,
  input  wire logic                bready,
  output logic [1:0]               bresp,
  input  wire logic                arvalid,
  output logic                     arready,
  input  wire logic [7:0]          araddr,
  output logic                     rvalid,
  input  wire logic                rready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  // Interrupt sources
  input  wire vmei_pkg::vmei_src_t src,
  // Acknowledge cycle
  input  wire vmei_pkg::vmei_iack_t iack,
  output logic [7:0]               vec_data_o,
  output logic                     vec_data_oe,
  output logic                     vec_dtack,
  output logic                     iack_out_n,
  // Request lines and local interrupt
  output logic [7:1]               vme_irq_out,
  output logic                     local_irq_line
);
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_err;
  logic        rd_en;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_err;
  logic [31:0] wmask;
  logic [31:0] vme_irq_enable_reg_q;
  logic [31:0] enable_d;
  logic [31:0] vme_irq_status_reg_q;
  logic [31:0] status_d;
  logic [31:0] soft_trig;
  logic [31:0] set_v;
  logic [31:0] clr_v;
  logic [31:0] clr_ack;
  logic [63:0] vme_irq_level_map_q;
  logic [6:0]  vector_base_reg_q;
  logic        syscon_q;
  logic [1:0]  evt_q;
  logic [1:0]  evt_d;
  logic [1:0]  evt_mask_q;
  logic [7:0]  drv_q;
  logic [7:0]  drv_d;
  logic [15:0] act_d;
  logic [15:0] act_q;
  logic [2:0]  lvl [`VMEI_NSRC];
  logic        go;
  logic        hit;
  logic        fsoft_here;
  logic        msoft_here;
  logic        done;
  logic [2:0]  lvl_q;
  vmei_pkg::vmei_state_t st_q;
  vmei_pkg::vmei_sel_t   sel_q;

  vmei_axil u_bus (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awvalid (awvalid),
    .awready (awready),
    .awaddr  (awaddr),
    .wvalid  (wvalid),
    .wready  (wready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .bvalid  (bvalid),
    .bready  (bready),
    .bresp   (bresp),
    .arvalid (arvalid),
    .arready (arready),
    .araddr  (araddr),
    .rvalid  (rvalid),
    .rready  (rready),
    .rdata   (rdata),
    .rresp   (rresp),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_err  (wr_err),
    .rd_en   (rd_en),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_err  (rd_err)
  );

  // Byte-lane mask of the current write
  assign wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  assign wr_err = !(wr_addr[7:5] == 3'h0 && wr_addr[1:0] == 2'h0);
  assign rd_err = !(rd_addr[7:5] == 3'h0 && rd_addr[1:0] == 2'h0);

  // Enable register; a one over a zero soft bit is a trigger
  always_comb
  begin
    enable_d  = vme_irq_enable_reg_q;
    soft_trig = 32'h0000_0000;
    if (wr_en && wr_addr == `VMEI_OFS_ENABLE)
    begin
      enable_d  = (vme_irq_enable_reg_q & ~wmask) | (wr_data & wmask);
      soft_trig = wr_data & wmask & ~vme_irq_enable_reg_q & `VMEI_SOFT_BITS;
    end
  end

  always_ff @(posedge aclk)
    if (!aresetn)
      vme_irq_enable_reg_q <= `VMEI_RST_WORD;
    else
      vme_irq_enable_reg_q <= enable_d & `VMEI_STAT_VALID;

  // Source set vector; local inputs set every cycle they are high
  assign set_v = soft_trig | {16'h0000, 1'b0, src.mailbox_src, src.pci_abort_src,
                 src.vme_bus_err_src, src.dma, src.local_irq_src};
  assign clr_v = (wr_en && wr_addr == `VMEI_OFS_STATUS) ? (wr_data & wmask) : 32'h0;

  // Status: set wins over clear, so a still-high local input survives a clear
  assign status_d = ((vme_irq_status_reg_q & ~clr_v & ~clr_ack) | set_v)
                    & `VMEI_STAT_VALID;

  always_ff @(posedge aclk)
    if (!aresetn)
      vme_irq_status_reg_q <= `VMEI_RST_WORD;
    else
      vme_irq_status_reg_q <= status_d;

  // Mapping, vector and control registers
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      vme_irq_level_map_q <= {`VMEI_RST_WORD, `VMEI_RST_WORD};
      vector_base_reg_q   <= `VMEI_RST_VECTOR;
      syscon_q            <= 1'b0;
      evt_mask_q          <= `VMEI_RST_EVT;
    end
    else if (wr_en)
    begin
      if (wr_addr == `VMEI_OFS_MAP0)
        vme_irq_level_map_q[31:0] <= (vme_irq_level_map_q[31:0] & ~wmask) | (wr_data & wmask);
      if (wr_addr == `VMEI_OFS_MAP1)
        vme_irq_level_map_q[63:32] <= (vme_irq_level_map_q[63:32] & ~wmask) | (wr_data & wmask);
      if (wr_addr == `VMEI_OFS_VECTOR && wr_strb[0])
        vector_base_reg_q <= wr_data[7:1];
      if (wr_addr == `VMEI_OFS_CTRL && wr_strb[0])
        syscon_q <= wr_data[`VMEI_CTRL_SYSCON];
      if (wr_addr == `VMEI_OFS_EVTMSK && wr_strb[0])
        evt_mask_q <= wr_data[1:0];
    end

  // Per-source level and activity
  for (genvar s = 0; s < `VMEI_NSRC; s++)
  begin : g_src
    assign lvl[s] = vme_irq_level_map_q[4*s +: 3];
    assign act_d[s] = status_d[s] && enable_d[s] && lvl[s] != 3'h0;
    assign act_q[s] = vme_irq_status_reg_q[s] && vme_irq_enable_reg_q[s] && lvl[s] != 3'h0;
  end

  // Per-level drive; several sources may share a level
  assign drv_d[0] = 1'b0;
  for (genvar l = 1; l < 8; l++)
  begin : g_lvl
    always_comb
    begin
      drv_d[l] = status_d[`VMEI_FSOFT_LSB + l] && enable_d[`VMEI_FSOFT_LSB + l];
      for (int s = 0; s < `VMEI_NSRC; s++)
        if (act_d[s] && lvl[s] == 3'(l))
          drv_d[l] = 1'b1;
    end
    fsoft_line_a: assert property (@(posedge aclk) disable iff (!aresetn)
      vme_irq_status_reg_q[`VMEI_FSOFT_LSB + l] && vme_irq_enable_reg_q[`VMEI_FSOFT_LSB + l]
      |-> drv_q[l])
      else $error("fixed soft bit set but its line is idle");
  end

  // Lines follow next status so a soft release and its clear coincide
  always_ff @(posedge aclk)
    if (!aresetn)
      drv_q <= 8'h00;
    else
      drv_q <= drv_d;

  assign vme_irq_out = drv_q[7:1];

  // Acknowledge decode
  assign go  = iack.strobe && (!iack.daisy_in_n || syscon_q);
  assign hit = drv_q[iack.level];
  assign fsoft_here = vme_irq_status_reg_q[`VMEI_FSOFT_LSB + {2'b00, iack.level}]
                      && vme_irq_enable_reg_q[`VMEI_FSOFT_LSB + {2'b00, iack.level}]
                      && iack.level != 3'h0;
  assign msoft_here = act_q[`VMEI_SRC_MSOFT] && lvl[`VMEI_SRC_MSOFT] == iack.level;
  assign done = st_q == vmei_pkg::ST_ANSWER && !iack.strobe;

  // Soft sources are released by the acknowledge itself
  always_comb
  begin
    clr_ack = 32'h0000_0000;
    if (done && sel_q == vmei_pkg::SEL_FIXED)
      clr_ack[`VMEI_FSOFT_LSB + {2'b00, lvl_q}] = 1'b1;
    if (done && sel_q == vmei_pkg::SEL_MSOFT)
      clr_ack[`VMEI_SRC_MSOFT] = 1'b1;
  end

  // Acknowledge state machine; the vector stands until the strobe drops
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      st_q        <= vmei_pkg::ST_IDLE;
      sel_q       <= vmei_pkg::SEL_OTHER;
      lvl_q       <= 3'h0;
      vec_data_o  <= 8'h00;
      vec_data_oe <= 1'b0;
      vec_dtack   <= 1'b0;
      iack_out_n  <= 1'b1;
    end
    else
      case (st_q)
        vmei_pkg::ST_IDLE:
          if (go && hit)
          begin
            st_q        <= vmei_pkg::ST_ANSWER;
            lvl_q       <= iack.level;
            vec_data_oe <= 1'b1;
            vec_dtack   <= 1'b1;
            if (fsoft_here)
            begin
              sel_q      <= vmei_pkg::SEL_FIXED;
              vec_data_o <= {vector_base_reg_q, 1'b0};
            end
            else if (msoft_here)
            begin
              sel_q      <= vmei_pkg::SEL_MSOFT;
              vec_data_o <= {vector_base_reg_q, 1'b0};
            end
            else
            begin
              sel_q      <= vmei_pkg::SEL_OTHER;
              vec_data_o <= {vector_base_reg_q, 1'b1};
            end
          end
          else if (go)
          begin
            st_q       <= vmei_pkg::ST_PASS;
            iack_out_n <= 1'b0;
          end
        vmei_pkg::ST_ANSWER:
          if (!iack.strobe)
          begin
            st_q        <= vmei_pkg::ST_IDLE;
            vec_data_oe <= 1'b0;
            vec_dtack   <= 1'b0;
          end
        vmei_pkg::ST_PASS:
          if (!iack.strobe)
          begin
            st_q       <= vmei_pkg::ST_IDLE;
            iack_out_n <= 1'b1;
          end
        default:
          st_q <= vmei_pkg::ST_IDLE;
      endcase

  // Events: sticky, cleared by reading, a new event beats the read
  always_comb
  begin
    evt_d = evt_q;
    if (rd_en && rd_addr == `VMEI_OFS_EVT)
      evt_d = 2'h0;
    if (done && sel_q != vmei_pkg::SEL_OTHER)
      evt_d[`VMEI_EVT_ACKDONE] = 1'b1;
    if (done)
      evt_d[`VMEI_EVT_SERVED] = 1'b1;
  end

  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      evt_q          <= `VMEI_RST_EVT;
      local_irq_line <= 1'b0;
    end
    else
    begin
      evt_q          <= evt_d;
      local_irq_line <= |(evt_d & evt_mask_q);
    end

  // Read mux; unmapped offsets answer zero with an error response
  always_comb
  begin
    rd_data = 32'h0000_0000;
    case (rd_addr)
      `VMEI_OFS_ENABLE: rd_data = vme_irq_enable_reg_q;
      `VMEI_OFS_STATUS: rd_data = vme_irq_status_reg_q;
      `VMEI_OFS_MAP0:   rd_data = vme_irq_level_map_q[31:0];
      `VMEI_OFS_MAP1:   rd_data = vme_irq_level_map_q[63:32];
      `VMEI_OFS_VECTOR: rd_data = {24'h000000, vector_base_reg_q, 1'b0};
      `VMEI_OFS_CTRL:   rd_data = {31'h00000000, syscon_q};
      `VMEI_OFS_EVT:    rd_data = {30'h00000000, evt_q};
      `VMEI_OFS_EVTMSK: rd_data = {30'h00000000, evt_mask_q};
      default:          rd_data = 32'h0000_0000;
    endcase
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  quiet_lines_a: assert property (
    (vme_irq_status_reg_q & vme_irq_enable_reg_q) == 32'h0 && $stable(vme_irq_enable_reg_q)
    |-> drv_q == 8'h00)
    else $error("line driven with no enabled active source");
  dma_sets_a: assert property (
    src.dma |=> vme_irq_status_reg_q[`VMEI_SRC_DMA])
    else $error("dma event did not set its status");
  local_level_a: assert property (
    src.local_irq_src[0] |=> vme_irq_status_reg_q[0])
    else $error("high local input lost its status");
  status_held_a: assert property (
    vme_irq_status_reg_q[`VMEI_SRC_VME_BUS_ERR_SRC] && !(wr_en && wr_addr == `VMEI_OFS_STATUS)
    |=> vme_irq_status_reg_q[`VMEI_SRC_VME_BUS_ERR_SRC])
    else $error("bus error status dropped without a write");
  roak_clear_a: assert property (
    clr_ack != 32'h0 && (soft_trig & clr_ack) == 32'h0
    |=> (vme_irq_status_reg_q & $past(clr_ack)) == 32'h0)
    else $error("soft status not cleared on acknowledge");
  ack_done_a: assert property (
    done && sel_q != vmei_pkg::SEL_OTHER |=> evt_q[`VMEI_EVT_ACKDONE])
    else $error("soft acknowledge raised no done event");
  vec_value_a: assert property (
    $rose(vec_data_oe) |-> vec_data_o[0] == (sel_q == vmei_pkg::SEL_OTHER))
    else $error("vector lsb does not match source kind");
  daisy_gate_a: assert property (
    $rose(vec_data_oe) |-> $past(go) && $past(hit))
    else $error("answer without daisy input or driven level");
  syscon_a: assert property (
    st_q == vmei_pkg::ST_IDLE && iack.strobe && syscon_q && iack.daisy_in_n && hit
    |=> vec_data_oe && vec_dtack)
    else $error("system controller ignored a valid acknowledge");
  pass_on_a: assert property (
    st_q == vmei_pkg::ST_IDLE && go && !hit |=> !iack_out_n && !vec_data_oe)
    else $error("foreign level not passed down the chain");
  soft_first_a: assert property (
    st_q == vmei_pkg::ST_IDLE && go && hit && (fsoft_here || msoft_here)
    |=> sel_q != vmei_pkg::SEL_OTHER ##1 1'b1)
    else $error("soft source not served first");
  vec_hold_a: assert property (
    vec_data_oe && iack.strobe |=> vec_data_oe && $stable(vec_data_o))
    else $error("vector dropped while strobe held");
endmodule
`default_nettype wire

// >>> design/vmei_consts.svh
// Register offsets, field positions and reset values of the VMEbus interrupter
`ifndef VMEI_CONSTS_SVH
`define VMEI_CONSTS_SVH
`define VMEI_OFS_ENABLE  8'h00
`define VMEI_OFS_STATUS  8'h04
`define VMEI_OFS_MAP0    8'h08
`define VMEI_OFS_MAP1    8'h0c
`define VMEI_OFS_VECTOR  8'h10
`define VMEI_OFS_CTRL    8'h14
`define VMEI_OFS_EVT     8'h18
`define VMEI_OFS_EVTMSK  8'h1c
`define VMEI_NSRC        16
`define VMEI_SRC_DMA     8
`define VMEI_SRC_VME_BUS_ERR_SRC    9
`define VMEI_SRC_PCI_ABORT_SRC    10
`define VMEI_SRC_MBOX    11
`define VMEI_SRC_MSOFT   15
`define VMEI_FSOFT_LSB   24
`define VMEI_STAT_VALID  32'hfe00_ffff
`define VMEI_SOFT_BITS   32'hfe00_8000
`define VMEI_EVT_ACKDONE 0
`define VMEI_EVT_SERVED  1
`define VMEI_CTRL_SYSCON 0
`define VMEI_RST_WORD    32'h0000_0000
`define VMEI_RST_VECTOR  7'h00
`define VMEI_RST_EVT     2'h0
`define VMEI_RESP_OKAY   2'h0
`define VMEI_RESP_SLVERR 2'h2
`endif

// >>> design/vmei_pkg.sv
// Types shared by the VMEbus interrupter files
package vmei_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_ANSWER, ST_PASS} vmei_state_t;
  typedef enum logic [1:0] {SEL_FIXED, SEL_MSOFT, SEL_OTHER} vmei_sel_t;
  // Acknowledge cycle as seen on the VMEbus side
  typedef struct packed {
    logic       strobe;
    logic [2:0] level;
    logic       daisy_in_n;
  } vmei_iack_t;
  // Hardware interrupt sources
  typedef struct packed {
    logic [7:0] local_irq_src;
    logic       dma;
    logic       vme_bus_err_src;
    logic       pci_abort_src;
    logic [3:0] mailbox_src;
  } vmei_src_t;
endpackage

// >>> design/vmei_axil.sv
// AXI4-Lite slave front end producing single-cycle register strobes
`timescale 1ns/1ps
`default_nettype none
`include "vmei_consts.svh"
module vmei_axil (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // Register side
  output logic             wr_en,
  output logic [7:0]       wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  input  wire logic        wr_err,
  output logic             rd_en,
  output logic [7:0]       rd_addr,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_err
);
  logic aw_full_q;
  logic w_full_q;
  logic ar_full_q;

  // A write fires once both halves are held and no answer is pending
  assign wr_en = aw_full_q && w_full_q && !bvalid;
  assign rd_en = ar_full_q && !rvalid;

  // Write address holding
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      awready   <= 1'b1;
      aw_full_q <= 1'b0;
      wr_addr   <= 8'h00;
    end
    else if (awvalid && awready)
    begin
      wr_addr   <= awaddr;
      awready   <= 1'b0;
      aw_full_q <= 1'b1;
    end
    else if (wr_en)
    begin
      awready   <= 1'b1;
      aw_full_q <= 1'b0;
    end

  // Write data holding, independent of address order
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      wready   <= 1'b1;
      w_full_q <= 1'b0;
      wr_data  <= 32'h0000_0000;
      wr_strb  <= 4'h0;
    end
    else if (wvalid && wready)
    begin
      wr_data  <= wdata;
      wr_strb  <= wstrb;
      wready   <= 1'b0;
      w_full_q <= 1'b1;
    end
    else if (wr_en)
    begin
      wready   <= 1'b1;
      w_full_q <= 1'b0;
    end

  // Write response
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp  <= `VMEI_RESP_OKAY;
    end
    else if (wr_en)
    begin
      bvalid <= 1'b1;
      bresp  <= wr_err ? `VMEI_RESP_SLVERR : `VMEI_RESP_OKAY;
    end
    else if (bready)
      bvalid <= 1'b0;

  // Read address; arready returns only after the data is taken
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      arready   <= 1'b1;
      ar_full_q <= 1'b0;
      rd_addr   <= 8'h00;
    end
    else if (arvalid && arready)
    begin
      rd_addr   <= araddr;
      arready   <= 1'b0;
      ar_full_q <= 1'b1;
    end
    else
    begin
      if (rd_en)
        ar_full_q <= 1'b0;
      if (rvalid && rready)
        arready <= 1'b1;
    end

  // Read data, sampled on the strobe cycle
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= `VMEI_RESP_OKAY;
    end
    else if (rd_en)
    begin
      rvalid <= 1'b1;
      rdata  <= rd_data;
      rresp  <= rd_err ? `VMEI_RESP_SLVERR : `VMEI_RESP_OKAY;
    end
    else if (rready)
      rvalid <= 1'b0;
endmodule
`default_nettype wire

// >>> sim/vmei_iack_model.sv
// Behavioural VMEbus interrupt handler running acknowledge cycles
`timescale 1ns/1ps
`default_nettype none
module vmei_iack_model #(
  parameter int HOLD = 2
) (
  // Clock
  input  wire logic                aclk,
  // Answer from the interrupter
  input  wire logic [7:0]          vec_data_o,
  input  wire logic                vec_data_oe,
  input  wire logic                vec_dtack,
  input  wire logic                iack_out_n,
  // Acknowledge cycle toward the interrupter
  output var vmei_pkg::vmei_iack_t iack
);
  // Idle: no strobe, daisy input released
  initial iack = '{strobe: 1'b0, level: 3'h0, daisy_in_n: 1'b1};

  // One cycle at level lv; extra stretches the strobe for a slow handler
  task automatic run(input logic [2:0] lv, input logic dn, input int extra,
                     output logic [7:0] vec, output logic ans, output logic pas);
    int n;
    n = 0;
    ans = 1'b0;
    pas = 1'b0;
    vec = 8'h00;
    @(posedge aclk);
    iack <= '{strobe: 1'b1, level: lv, daisy_in_n: dn};
    while (n < 8 && !ans && !pas)
    begin
      @(posedge aclk);
      n++;
      ans = (vec_dtack === 1'b1) && (vec_data_oe === 1'b1);
      pas = (iack_out_n === 1'b0);
      vec = vec_data_o;
    end
    repeat (HOLD + extra) @(posedge aclk);
    // Level lines show the inverse once released, never a stale value
    iack <= '{strobe: 1'b0, level: ~lv, daisy_in_n: 1'b1};
    repeat (2) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// >>> sim/tb_vme_interrupter.sv
// Self-checking bench for the VMEbus interrupter
`timescale 1ns/1ps
`default_nettype none
`include "vmei_consts.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
  $display("mismatch at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_vme_interrupter;
  typedef struct {logic [14:0] sv; int b; logic [2:0] lv; logic en;} vmei_row_t;
  logic                 aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]           awaddr, araddr;
  logic [31:0]          wdata, rd;
  logic [3:0]           wstrb;
  wire logic            awready, wready, bvalid, arready, rvalid;
  wire logic [1:0]      bresp, rresp;
  wire logic [31:0]     rdata;
  vmei_pkg::vmei_src_t  src;
  vmei_pkg::vmei_iack_t iack;
  wire logic [7:0]      vec_data_o;
  wire logic            vec_data_oe, vec_dtack, iack_out_n, local_irq_line;
  wire logic [7:1]      vme_irq_out;
  int                   bad_count, checks_done;
  logic [7:0]           v;
  logic [6:0]           ex;
  logic                 ans, pas;
  logic [1:0]           rsp;
  // Hardware sources: struct value, enable bit, level, enabled
  vmei_row_t            rows [7] = '{'{15'h0400, 3, 3'h4, 1'b1}, '{15'h0040, 8, 3'h2, 1'b1},
    '{15'h0020, 9, 3'h5, 1'b1}, '{15'h0010, 10, 3'h7, 1'b1}, '{15'h0004, 13, 3'h1, 1'b1},
    '{15'h0080, 0, 3'h0, 1'b1}, '{15'h0040, 8, 3'h3, 1'b0}};

  vmei_top dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
    .rdata, .rresp, .src, .iack, .vec_data_o, .vec_data_oe, .vec_dtack, .iack_out_n,
    .vme_irq_out, .local_irq_line);

  vmei_iack_model hm (.aclk, .vec_data_o, .vec_data_oe, .vec_dtack, .iack_out_n, .iack);

  // 100 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Write: address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  // Read one word
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  // Let n edges pass, then look after their updates land
  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask

  task automatic report_and_stop();
    if (bad_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial
  begin
    #200000;
    bad_count++;
    report_and_stop();
  end

  // Main sequence
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hf;
    src = '0;
    aresetn = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axw(`VMEI_OFS_VECTOR, 32'h0000_00a4);
    foreach (rows[i])
    begin
      axw(`VMEI_OFS_ENABLE, rows[i].en ? 32'h1 << rows[i].b : 32'h0);
      axw(rows[i].b < 8 ? `VMEI_OFS_MAP0 : `VMEI_OFS_MAP1,
          32'(rows[i].lv) << (4 * (rows[i].b % 8)));
      src <= rows[i].sv;
      @(posedge aclk);
      src <= '0;
      settle(3);
      ex = (rows[i].lv == 3'h0 || !rows[i].en) ? 7'h00 : 7'(1 << (rows[i].lv - 1));
      `CHK(vme_irq_out, ex)
      axr(`VMEI_OFS_STATUS);
      `CHK(rd, 32'h1 << rows[i].b)
      if (ex != 7'h00)
      begin
        hm.run(rows[i].lv, 1'b0, 0, v, ans, pas);
        settle(0);
        `CHK(v, 8'ha5)
        `CHK(vme_irq_out, ex)
      end
      axw(`VMEI_OFS_STATUS, 32'h1 << rows[i].b);
      settle(2);
      `CHK(vme_irq_out, 7'h00)
    end
    // Fixed soft interrupts, ack-done event masked on the first level only
    for (int l = 1; l < 8; l++)
    begin
      axw(`VMEI_OFS_EVTMSK, 32'(l > 1));
      axw(`VMEI_OFS_ENABLE, 32'h0);
      axw(`VMEI_OFS_ENABLE, 32'h1 << (24 + l));
      settle(2);
      `CHK(vme_irq_out, 7'(1 << (l - 1)))
      hm.run(3'(l), 1'b0, (l % 2) * 3, v, ans, pas);
      settle(0);
      `CHK(v, 8'ha4)
      `CHK(vme_irq_out, 7'h00)
      axr(`VMEI_OFS_STATUS);
      `CHK(rd, 32'h0)
      `CHK(local_irq_line, l > 1)
      axr(`VMEI_OFS_EVT);
      `CHK(rd, 32'h3)
      settle(1);
      `CHK(local_irq_line, 1'b0)
    end
    // All seven lines at once
    axw(`VMEI_OFS_ENABLE, 32'h0);
    axw(`VMEI_OFS_ENABLE, 32'hfe00_0000);
    settle(2);
    `CHK(vme_irq_out, 7'h7f)
    axw(`VMEI_OFS_ENABLE, 32'h0);
    axw(`VMEI_OFS_STATUS, 32'hfe00_0000);
    // Mappable soft and dma sharing level 3: soft served first
    axw(`VMEI_OFS_MAP1, 32'h3000_0003);
    axw(`VMEI_OFS_ENABLE, 32'h0000_0100);
    src <= 15'h0040;
    @(posedge aclk);
    src <= '0;
    axw(`VMEI_OFS_ENABLE, 32'h0000_8100);
    settle(2);
    hm.run(3'h3, 1'b0, 0, v, ans, pas);
    settle(0);
    `CHK(v, 8'ha4)
    `CHK(vme_irq_out, 7'h04)
    hm.run(3'h3, 1'b0, 0, v, ans, pas);
    `CHK(v, 8'ha5)
    // Daisy input high: refused, then answered as system controller
    hm.run(3'h3, 1'b1, 0, v, ans, pas);
    `CHK({ans, pas}, 2'b00)
    axw(`VMEI_OFS_CTRL, 32'h1);
    hm.run(3'h3, 1'b1, 0, v, ans, pas);
    `CHK(ans, 1'b1)
    axw(`VMEI_OFS_CTRL, 32'h0);
    hm.run(3'h5, 1'b0, 0, v, ans, pas);
    `CHK({ans, pas}, 2'b01)
    // Local input still high when status is cleared
    axw(`VMEI_OFS_MAP0, 32'h0000_0060);
    axw(`VMEI_OFS_ENABLE, 32'h0000_0002);
    src <= 15'h0100;
    settle(3);
    `CHK(vme_irq_out, 7'h20)
    axw(`VMEI_OFS_STATUS, 32'h0000_0002);
    settle(2);
    `CHK(vme_irq_out, 7'h20)
    // Reset in mid-run, unmapped places refused
    @(posedge aclk);
    aresetn <= 1'b0;
    src <= '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    settle(0);
    `CHK(vme_irq_out, 7'h00)
    axr(`VMEI_OFS_ENABLE);
    `CHK(rd, 32'h0)
    axr(8'h20);
    `CHK(rsp, `VMEI_RESP_SLVERR)
    axw(8'h22, 32'h1);
    `CHK(rsp, `VMEI_RESP_SLVERR)
    // Partial byte lanes touch only the lanes offered
    wstrb <= 4'h2;
    axw(`VMEI_OFS_MAP0, 32'hffff_ffff);
    wstrb <= 4'hf;
    axr(`VMEI_OFS_MAP0);
    `CHK(rd, 32'h0000_ff00)
    report_and_stop();
  end
endmodule
`default_nettype wire
